// [ssf_line_model.sv]
// Line-side partner of the serial status block: reports frames, takes bytes.
// Assumes pclk from the bench; its tasks are entered just after a rising edge.

////////////////////////////////////////////////////////////////////////////////
module ssf_line_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Transmit side
  input wire logic tx_load,
  output logic tx_shift_ready,
  output logic tx_last_bit = 1'b0,
  // Receive side
  output logic rx_done = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_mp_bit = 1'b0,
  output logic rx_parity_bad = 1'b0,
  output logic rx_error_signal = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy = 4'h0;

  // The shifter is busy for eight cycles per byte and then flags its last bit.
  assign tx_shift_ready = (busy == 4'h0);
  always @(posedge pclk) begin
    if (!presetn)
      busy <= 4'h0;
    else if (tx_load)
      busy <= 4'h8;
    else if (busy != 4'h0)
      busy <= busy - 4'h1;
    tx_last_bit <= (busy == 4'h1);
  end

  task send(input logic [7:0] d, input logic mp, input logic bad);
    @(posedge pclk);
    rx_done <= 1'b1;
    rx_data <= d;
    rx_mp_bit <= mp;
    rx_parity_bad <= bad;
    @(posedge pclk);
    // Outside a frame the lines carry nothing valid, so they show the inverse.
    rx_done <= 1'b0;
    rx_data <= ~d;
    rx_mp_bit <= ~mp;
    rx_parity_bad <= ~bad;
  endtask : send

  task err_pulse;
    @(posedge pclk);
    rx_error_signal <= 1'b1;
    @(posedge pclk);
    rx_error_signal <= 1'b0;
  endtask : err_pulse
endmodule : ssf_line_model

// [ssf_pkg.sv]
// Constants of the serial status flag block and its bit-time delay timer.
// Assumes one clock, pclk, and an active-low asynchronous reset, presetn.

////////////////////////////////////////////////////////////////////////////////
package ssf_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_ETU = 8'h08;
  localparam logic [7:0] ADDR_TX_DATA = 8'h0c;
  localparam logic [7:0] ADDR_RX_DATA = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // Status register bit positions.
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_RX_FULL = 6;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_ERR_SIGNAL = 4;
  localparam int BIT_PARITY = 3;
  localparam int BIT_TX_COMPLETE = 2;
  localparam int BIT_RX_MP = 1;
  localparam int BIT_TX_MP = 0;
  localparam logic [7:0] STATUS_RESET = 8'h84;
  // Control register bit positions.
  localparam int CTL_RX_ENABLE = 0;
  localparam int CTL_TX_ENABLE = 1;
  localparam int CTL_TX_END_QUAL = 2;
  localparam int CTL_GUARD_MODE = 3;
  localparam int CTL_BLOCK_MODE = 4;
  localparam int CTL_CARD_MODE = 5;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  // Bit time in pclk cycles; the reset value is a plain default.
  localparam logic [15:0] ETU_RESET = 16'h0174;
  // Transmit-end delays in half bit times: 2.5, 1.5 and 1.0 bit times.
  localparam logic [2:0] HALF_ETU_GUARD0_BLOCK0 = 3'h5;
  localparam logic [2:0] HALF_ETU_GUARD0_BLOCK1 = 3'h3;
  localparam logic [2:0] HALF_ETU_GUARD1 = 3'h2;
  // Interrupt status bit positions.
  localparam int IRQ_RX_FULL = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_ERR_SIGNAL = 3;
  localparam int IRQ_PARITY = 4;
  localparam int IRQ_TX_COMPLETE = 5;
  localparam int IRQ_WIDTH = 6;
endpackage : ssf_pkg

////////////////////////////////////////////////////////////////////////////////
// Counts half bit times after a byte start and pulses done once.
module ssf_delay (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic [2:0] half_units,
  input wire logic [15:0] cycles_per_etu,
  // Result
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [19:0] count;
    logic [19:0] target;
    logic done;
  } ssf_delay_type;

  ssf_delay_type st;
  ssf_delay_type next_st;

  // Counting in steps of two against units times bit time keeps half bit times exact.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.busy = 1'b1;
      next_st.count = 20'h0_0000;
      next_st.target = 20'(half_units) * 20'(cycles_per_etu);
    end else if (st.busy) begin
      next_st.count = st.count + 20'h0_0002;
      if (next_st.count >= st.target) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule : ssf_delay

// [ssf_top.sv]
// Status flag logic of a serial channel with an APB register port.
// Assumes a line-side shifter that reports frame events as one-cycle pulses on pclk.

////////////////////////////////////////////////////////////////////////////////
module ssf_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive side
  input wire logic rx_done,
  input wire logic [7:0] rx_data,
  input wire logic rx_mp_bit,
  input wire logic rx_parity_bad,
  input wire logic rx_error_signal,
  // Transmit side
  input wire logic tx_shift_ready,
  input wire logic tx_last_bit,
  output logic tx_load,
  output logic [7:0] tx_byte,
  output logic tx_mp_bit,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic ovr;
    logic err_sig;
    logic par_err;
    logic tx_end;
    logic rx_mp;
    logic tx_mp;
    logic [4:0] arm;
    logic [5:0] ctrl;
    logic [15:0] etu;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [5:0] ists;
    logic [5:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic tx_load;
    logic [7:0] tx_byte;
    logic tx_mp_out;
    logic start;
    logic [2:0] half;
  } ssf_state_type;

  ssf_state_type st;
  ssf_state_type next_st;
  logic timer_done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, ssf_pkg::ADDR_STATUS) || hit(a, ssf_pkg::ADDR_CONTROL) ||
             hit(a, ssf_pkg::ADDR_ETU) || hit(a, ssf_pkg::ADDR_TX_DATA) ||
             hit(a, ssf_pkg::ADDR_RX_DATA) || hit(a, ssf_pkg::ADDR_IRQ_STATUS) ||
             hit(a, ssf_pkg::ADDR_IRQ_MASK);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////////
  // Control bit views.
  logic rx_en;
  logic tx_en;
  logic tx_eq;
  logic guard;
  logic block;
  logic card;
  logic [7:0] status;

  assign rx_en = st.ctrl[ssf_pkg::CTL_RX_ENABLE];
  assign tx_en = st.ctrl[ssf_pkg::CTL_TX_ENABLE];
  assign tx_eq = st.ctrl[ssf_pkg::CTL_TX_END_QUAL];
  assign guard = st.ctrl[ssf_pkg::CTL_GUARD_MODE];
  assign block = st.ctrl[ssf_pkg::CTL_BLOCK_MODE];
  assign card = st.ctrl[ssf_pkg::CTL_CARD_MODE];

  // Bit 4 has its error-signal meaning only in card mode and reads 0 otherwise.
  assign status = {st.tx_empty, st.rx_full, st.ovr, card & st.err_sig,
                   st.par_err, st.tx_end, st.rx_mp, st.tx_mp};

  ////////////////////////////////////////////////////////////////////////////////
  // APB phases.
  logic setup;
  logic acc;
  logic wr;
  logic rd;

  assign setup = psel && !penable;
  assign acc = psel && penable && st.pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic [4:0] clr;
    logic [5:0] ev;
    logic [31:0] rv;
    clr = 5'h00;
    ev = 6'h00;
    rv = 32'h0000_0000;
    next_st = st;
    next_st.tx_load = 1'b0;
    next_st.start = 1'b0;

    // Read data is latched in the setup cycle, so the slave has no wait states.
    case (paddr)
      ssf_pkg::ADDR_STATUS: rv = {24'h00_0000, status};
      ssf_pkg::ADDR_CONTROL: rv = {26'h000_0000, st.ctrl};
      ssf_pkg::ADDR_ETU: rv = {16'h0000, st.etu};
      ssf_pkg::ADDR_TX_DATA: rv = {24'h00_0000, st.tx_buf};
      ssf_pkg::ADDR_RX_DATA: rv = {24'h00_0000, st.rx_buf};
      ssf_pkg::ADDR_IRQ_STATUS: rv = {26'h000_0000, st.ists};
      ssf_pkg::ADDR_IRQ_MASK: rv = {26'h000_0000, st.imask};
      default: rv = 32'h0000_0000;
    endcase
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped(paddr);
    next_st.prdata = setup ? rv : 32'h0000_0000;

    // A status read arms each clear-only flag that it returned as 1.
    if (rd && hit(paddr, ssf_pkg::ADDR_STATUS)) begin
      next_st.arm = st.prdata[7:3];
    end

    // Software writes; flag clears come first so hardware sets below override them.
    if (wr && hit(paddr, ssf_pkg::ADDR_STATUS)) begin
      clr = st.arm & ~pwdata[7:3];
      next_st.arm = st.arm & ~clr;
      next_st.tx_mp = pwdata[ssf_pkg::BIT_TX_MP];
      if (clr[4]) begin
        next_st.tx_empty = 1'b0;
        next_st.tx_end = 1'b0;
      end
      if (clr[3]) begin
        next_st.rx_full = 1'b0;
      end
      if (clr[2]) begin
        next_st.ovr = 1'b0;
      end
      if (clr[1]) begin
        next_st.err_sig = 1'b0;
      end
      if (clr[0]) begin
        next_st.par_err = 1'b0;
      end
    end
    if (wr && hit(paddr, ssf_pkg::ADDR_CONTROL)) begin
      next_st.ctrl = pwdata[5:0];
    end
    if (wr && hit(paddr, ssf_pkg::ADDR_ETU)) begin
      next_st.etu = pwdata[15:0];
    end
    if (wr && hit(paddr, ssf_pkg::ADDR_TX_DATA)) begin
      next_st.tx_buf = pwdata[7:0];
    end
    if (wr && hit(paddr, ssf_pkg::ADDR_IRQ_STATUS)) begin
      next_st.ists = st.ists & ~pwdata[5:0];
    end
    if (wr && hit(paddr, ssf_pkg::ADDR_IRQ_MASK)) begin
      next_st.imask = pwdata[5:0];
    end

    // Transmit hand-off to the shift register.
    if (!tx_en) begin
      next_st.tx_empty = 1'b1;
    end else if (!st.tx_empty && tx_shift_ready) begin
      next_st.tx_empty = 1'b1;
      next_st.tx_load = 1'b1;
      next_st.tx_byte = st.tx_buf;
      // Card mode frames carry no multiprocessor bit.
      next_st.tx_mp_out = st.tx_mp & !card;
      next_st.start = card;
      if (guard) begin
        next_st.half = ssf_pkg::HALF_ETU_GUARD1;
      end else if (block) begin
        next_st.half = ssf_pkg::HALF_ETU_GUARD0_BLOCK1;
      end else begin
        next_st.half = ssf_pkg::HALF_ETU_GUARD0_BLOCK0;
      end
      ev[ssf_pkg::IRQ_TX_EMPTY] = 1'b1;
    end

    // Transmit end.
    if (card) begin
      if (!tx_en && !tx_eq) begin
        next_st.tx_end = 1'b1;
      end
      if (timer_done && !st.err_sig && st.tx_empty) begin
        next_st.tx_end = 1'b1;
        ev[ssf_pkg::IRQ_TX_COMPLETE] = 1'b1;
      end
    end else begin
      if (!tx_en) begin
        next_st.tx_end = 1'b1;
      end
      if (tx_last_bit && st.tx_empty) begin
        next_st.tx_end = 1'b1;
        ev[ssf_pkg::IRQ_TX_COMPLETE] = 1'b1;
      end
    end

    // Reception; a cleared receive enable freezes every receive flag except the error-signal flag.
    if (rx_done && rx_en) begin
      if (!card) begin
        next_st.rx_mp = rx_mp_bit;
      end
      if (rx_parity_bad) begin
        next_st.par_err = 1'b1;
        ev[ssf_pkg::IRQ_PARITY] = 1'b1;
      end
      if (st.rx_full) begin
        next_st.ovr = 1'b1;
        ev[ssf_pkg::IRQ_OVERRUN] = 1'b1;
      end else if (!rx_parity_bad) begin
        next_st.rx_full = 1'b1;
        next_st.rx_buf = rx_data;
        ev[ssf_pkg::IRQ_RX_FULL] = 1'b1;
      end
    end
    if (card && rx_error_signal) begin
      next_st.err_sig = 1'b1;
      ev[ssf_pkg::IRQ_ERR_SIGNAL] = 1'b1;
    end

    next_st.ists = next_st.ists | ev;
    next_st.irq = |(next_st.ists & next_st.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.tx_empty <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_EMPTY];
      st.tx_end <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_COMPLETE];
      st.ctrl <= ssf_pkg::CONTROL_RESET;
      st.etu <= ssf_pkg::ETU_RESET;
    end else begin
      st <= next_st;
    end
  end

  ssf_delay u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .start(st.start),
    .half_units(st.half),
    .cycles_per_etu(st.etu),
    .done(timer_done)
  );

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign tx_load = st.tx_load;
  assign tx_byte = st.tx_byte;
  assign tx_mp_bit = st.tx_mp_out;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_empty_tx_off: assert property (!tx_en |=> st.tx_empty)
    else $error("tx empty not set while transmit disabled");

  a_empty_hand_off: assert property (
    tx_en && !st.tx_empty && tx_shift_ready |=> st.tx_empty && tx_load)
    else $error("hand-off did not set tx empty");

  a_full_load_data: assert property (
    rx_done && rx_en && !rx_parity_bad && !st.rx_full |=> st.rx_full && st.rx_buf == $past(rx_data))
    else $error("clean reception did not fill receive buffer");

  a_full_rx_off_hold: assert property (
    st.rx_full && !rx_en && !wr |=> st.rx_full)
    else $error("receive full lost while receive disabled");

  a_overrun_set: assert property (rx_done && rx_en && st.rx_full |=> st.ovr)
    else $error("overrun not flagged");

  a_err_signal_set: assert property (card && rx_error_signal |=> st.err_sig)
    else $error("error signal not flagged");

  a_parity_set: assert property (rx_done && rx_en && rx_parity_bad |=> st.par_err)
    else $error("parity error not flagged");

  a_rx_mp_capture: assert property (
    rx_done && rx_en && !card |=> st.rx_mp == $past(rx_mp_bit))
    else $error("receive multiprocessor bit not captured");

  a_rx_mp_stable: assert property (
    !(rx_done && rx_en && !card) |=> $stable(st.rx_mp))
    else $error("receive multiprocessor bit changed without capture");

  a_tx_mp_normal: assert property (
    !card && tx_en && !st.tx_empty && tx_shift_ready |=> tx_mp_bit == $past(st.tx_mp))
    else $error("transmit multiprocessor bit not sent");

  a_write_one_keeps: assert property (
    wr && hit(paddr, ssf_pkg::ADDR_STATUS) && pwdata[6] && st.rx_full |=> st.rx_full)
    else $error("writing one cleared a flag");

  a_clear_needs_arm: assert property (
    wr && hit(paddr, ssf_pkg::ADDR_STATUS) && !st.arm[3] && st.rx_full |=> st.rx_full)
    else $error("flag cleared without a prior read of one");

  a_end_sw_clear: assert property (
    wr && hit(paddr, ssf_pkg::ADDR_STATUS) && st.arm[4] && !pwdata[ssf_pkg::BIT_TX_EMPTY] &&
    tx_en && !card && !tx_last_bit |=> !st.tx_end)
    else $error("clearing tx empty left transmit end set");

  a_end_delay: assert property (
    card && timer_done && !st.err_sig && st.tx_empty |=> st.tx_end)
    else $error("transmit end not set after delay");

  a_end_held: assert property (card && !tx_en && !tx_eq |=> st.tx_end[*2])
    else $error("transmit end not held while idle");

  // An unmasked receive event must raise the interrupt on the very next cycle.
  a_irq_rx_full: assert property (
    rx_done && rx_en && !rx_parity_bad && !st.rx_full && st.imask[ssf_pkg::IRQ_RX_FULL] |=> irq)
    else $error("interrupt not raised by unmasked event");
endmodule : ssf_top

// [testbench.sv]
// Self-checking bench of the serial status block through its APB port.
// Assumes the line-side partner model and the design package are compiled first.

////////////////////////////////////////////////////////////////////////////////
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ETU = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, slv, rx_done, rx_mp_bit, rx_parity_bad, rx_error_signal;
  logic tx_shift_ready, tx_last_bit, tx_load, tx_mp_bit, irq;
  logic [7:0] rx_data, tx_byte;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int hv[3] = '{5, 3, 2};
  logic [31:0] gb[3] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0008};

  always #20 pclk = ~pclk;

  ssf_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_done, .rx_data, .rx_mp_bit, .rx_parity_bad, .rx_error_signal,
    .tx_shift_ready, .tx_last_bit, .tx_load, .tx_byte, .tx_mp_bit, .irq);
  ssf_line_model lm (.pclk, .presetn, .tx_load, .tx_shift_ready, .tx_last_bit, .rx_done,
    .rx_data, .rx_mp_bit, .rx_parity_bad, .rx_error_signal);

  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task st(input logic [7:0] e);
    rd(ssf_pkg::ADDR_STATUS);
    chk("status", q, {24'h00_0000, e});
  endtask : st

  // Loads a byte, clears the empty flag with stw and waits for the hand-off.
  task sendtx(input logic [31:0] ctl, input logic [7:0] d, input logic [31:0] stw);
    int n;
    wr(ssf_pkg::ADDR_CONTROL, ctl);
    wr(ssf_pkg::ADDR_TX_DATA, {24'h00_0000, d});
    rd(ssf_pkg::ADDR_STATUS);
    wr(ssf_pkg::ADDR_STATUS, stw);
    n = 0;
    while (tx_load !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("tx_byte", {24'h00_0000, tx_byte}, {24'h00_0000, d});
  endtask : sendtx

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    st(8'h84);
    rd(8'h1c);
    chk("pslverr", {31'h0, slv}, 32'h0000_0001);
    chk("unmapped", q, 32'h0000_0000);
    $display("test reset done");
    wr(ssf_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    wr(ssf_pkg::ADDR_CONTROL, 32'h0000_0001);
    lm.send(8'h5a, 1'b1, 1'b0);
    wr(ssf_pkg::ADDR_STATUS, 32'h0000_0080);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    st(8'hc6);
    lm.send(8'ha5, 1'b1, 1'b0);
    st(8'he6);
    rd(ssf_pkg::ADDR_RX_DATA);
    chk("rx_data", q, 32'h0000_005a);
    wr(ssf_pkg::ADDR_CONTROL, 32'h0000_0000);
    lm.send(8'h11, 1'b0, 1'b0);
    st(8'he6);
    wr(ssf_pkg::ADDR_STATUS, 32'h0000_0080);
    st(8'h86);
    wr(ssf_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test receive done");
    wr(ssf_pkg::ADDR_CONTROL, 32'h0000_0003);
    lm.send(8'h33, 1'b0, 1'b1);
    st(8'h8c);
    sendtx(32'h0000_0003, 8'h3c, 32'h0000_0001);
    chk("tx_mp_bit", {31'h0, tx_mp_bit}, 32'h0000_0001);
    st(8'h81);
    $display("test normal transmit done");
    wr(ssf_pkg::ADDR_ETU, ETU);
    for (int i = 0; i < 3; i++) begin
      sendtx(32'h0000_0022 | gb[i], 8'h40 + 8'(i), 32'h0000_0000);
      chk("tx_mp_bit", {31'h0, tx_mp_bit}, 32'h0000_0000);
      st(8'h80);
      repeat (hv[i] * ETU / 2 + 2) @(posedge pclk);
      st(8'h84);
    end
    $display("test card transmit done");
    lm.err_pulse();
    st(8'h94);
    sendtx(32'h0000_0022, 8'h77, 32'h0000_0010);
    repeat (16) @(posedge pclk);
    st(8'h90);
    wr(ssf_pkg::ADDR_CONTROL, 32'h0000_0024);
    st(8'h90);
    wr(ssf_pkg::ADDR_CONTROL, 32'h0000_0021);
    lm.send(8'h66, 1'b1, 1'b0);
    st(8'hd4);
    rd(ssf_pkg::ADDR_RX_DATA);
    chk("rx_data", q, 32'h0000_0066);
    wr(ssf_pkg::ADDR_CONTROL, 32'h0000_0000);
    st(8'hc4);
    $display("test error signal done");
    results();
  end
endmodule : testbench
